/* File: rtl/usp_serial_port.sv */
// usp_serial_port: full-duplex serial port with shift-register and asynchronous modes.
// assumes a same-clock register port, a same-clock timer overflow tick, pins from outside.
`timescale 1ns/100ps
`default_nettype none
module usp_serial_port (
    // clock, reset, enable
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic       ce_i,
    // special function register port
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic       sfr_wr_i,
    input  wire logic       sfr_rd_i,
    input  wire logic [7:0] sfr_wdata_i,
    output logic [7:0]      sfr_rdata_o,
    // rate sources and options
    input  wire logic       baud_tick_i,
    input  wire logic       double_rate_i,
    input  wire logic       frame_error_access_select_i,
    // serial pins
    input  wire logic       rxd_i,
    output logic            rxd_o,
    output logic            rxd_oe_n_o,
    output logic            txd_o,
    // interrupt request
    output logic            serial_irq_o
);
    logic [1:0]         mode;
    logic               mp, ren, tb8, rb8, ti, ri, fe;
    logic [7:0]         rx_hold;
    logic               rxd_meta, rxd_sync;
    logic               div_phase, os_tick;
    usp_pkg::usp_line_t state;
    logic [10:0]        tx_shift;
    logic [3:0]         bit_left;
    logic [3:0]         os_cnt;
    logic               ph;
    logic [7:0]         m0_shift;
    logic               wr_serial_control, wr_serial_buffer, fes;
    logic               tx_fin, m0_rx_fin, m0_rx_go;
    logic               a_done, a_ninth, a_stop;
    logic [7:0]         a_data;
    logic               rx_done, rx_pass, rx_accept, rx_ninth_new;
    logic [7:0]         rx_byte;

    // ****************************************
    // register decode
    // ****************************************
    assign wr_serial_control = ce_i && sfr_wr_i && (sfr_addr_i == usp_pkg::SERIAL_CONTROL_ADDR);
    assign wr_serial_buffer = ce_i && sfr_wr_i && (sfr_addr_i == usp_pkg::SERIAL_BUFFER_ADDR);
    assign fes     = frame_error_access_select_i;

    // ****************************************
    // pin synchroniser and sample tick
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rxd_meta <= 1'b1;
            rxd_sync <= 1'b1;
        end else if (ce_i) begin
            rxd_meta <= rxd_i;
            rxd_sync <= rxd_meta;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            div_phase <= 1'b0;
        end else if (ce_i) begin
            div_phase <= ~div_phase;
        end
    end

    // timer tick for modes 1 and 3
    assign os_tick = (mode == usp_pkg::MODE_UART9F) ? (double_rate_i || div_phase) : baud_tick_i;

    // ****************************************
    // line engine: async transmit and mode 0
    // ****************************************
    // mode 0 receive start condition
    assign m0_rx_go  = (mode == usp_pkg::MODE_SHIFT) && ren && !ri && !wr_serial_buffer;
    assign tx_fin    = ce_i && (((state == usp_pkg::ln_tx_async) && os_tick &&
                       (os_cnt == usp_pkg::OS_LAST) && (bit_left == 4'h1)) ||
                       ((state == usp_pkg::ln_sync_tx) && ph && (bit_left == 4'h1)));
    assign m0_rx_fin = ce_i && (state == usp_pkg::ln_sync_rx) && ph && (bit_left == 4'h1);
    assign rxd_oe_n_o = (state != usp_pkg::ln_sync_tx);

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state    <= usp_pkg::ln_idle;
            tx_shift <= 11'h7FF;
            bit_left <= 4'h0;
            os_cnt   <= 4'h0;
            ph       <= 1'b0;
            m0_shift <= 8'h00;
            txd_o    <= 1'b1;
            rxd_o    <= 1'b1;
        end else if (ce_i) begin
            if (wr_serial_buffer && (state == usp_pkg::ln_idle || state == usp_pkg::ln_sync_rx)) begin
                ph     <= 1'b0;
                os_cnt <= 4'h0;
                txd_o  <= 1'b1;
                if (mode == usp_pkg::MODE_SHIFT) begin
                    tx_shift <= {3'h7, sfr_wdata_i};
                    bit_left <= usp_pkg::SYNC_BITS;
                    state    <= usp_pkg::ln_sync_tx;
                end else if (mode == usp_pkg::MODE_UART8) begin
                    tx_shift <= {2'h3, sfr_wdata_i, 1'b0};
                    bit_left <= usp_pkg::FRAME_BITS8;
                    state    <= usp_pkg::ln_tx_async;
                end else begin
                    tx_shift <= {1'b1, tb8, sfr_wdata_i, 1'b0};
                    bit_left <= usp_pkg::FRAME_BITS9;
                    state    <= usp_pkg::ln_tx_async;
                end
            end else begin
                case (state)
                    usp_pkg::ln_idle: begin
                        txd_o <= 1'b1;
                        rxd_o <= 1'b1;
                        ph    <= 1'b0;
                        if (m0_rx_go) begin
                            bit_left <= usp_pkg::SYNC_BITS;
                            state    <= usp_pkg::ln_sync_rx;
                        end
                    end
                    usp_pkg::ln_tx_async: begin
                        if (os_tick) begin
                            os_cnt <= os_cnt + 4'h1;
                            if (os_cnt == 4'h0) begin
                                txd_o    <= tx_shift[0];
                                tx_shift <= {1'b1, tx_shift[10:1]};
                            end else if (os_cnt == usp_pkg::OS_LAST) begin
                                bit_left <= bit_left - 4'h1;
                                if (bit_left == 4'h1) begin
                                    state <= usp_pkg::ln_idle;
                                end
                            end
                        end
                    end
                    usp_pkg::ln_sync_tx: begin
                        // two cycles per bit, lsb first
                        ph <= ~ph;
                        if (!ph) begin
                            txd_o    <= 1'b0;
                            rxd_o    <= tx_shift[0];
                            tx_shift <= {1'b1, tx_shift[10:1]};
                        end else begin
                            txd_o    <= 1'b1;
                            bit_left <= bit_left - 4'h1;
                            if (bit_left == 4'h1) begin
                                state <= usp_pkg::ln_idle;
                            end
                        end
                    end
                    usp_pkg::ln_sync_rx: begin
                        ph    <= ~ph;
                        txd_o <= ph;
                        if (ph) begin
                            m0_shift <= {rxd_sync, m0_shift[7:1]};
                            bit_left <= bit_left - 4'h1;
                            if (bit_left == 4'h1) begin
                                state <= usp_pkg::ln_idle;
                            end
                        end
                    end
                    default: state <= usp_pkg::ln_idle;
                endcase
            end
        end
    end

    // ****************************************
    // asynchronous receiver
    // ****************************************
    // receiver runs beside the transmitter
    usp_async_rx u_rx (
        .clk_i      (clk_i),
        .reset_i    (reset_i),
        .ce_i       (ce_i),
        .os_tick_i  (os_tick),
        .rx_en_i    (ren && (mode != usp_pkg::MODE_SHIFT)),
        .nine_bit_i (mode[1]),
        .rxd_i      (rxd_sync),
        .done_o     (a_done),
        .data_o     (a_data),
        .ninth_o    (a_ninth),
        .stop_o     (a_stop)
    );

    // ****************************************
    // receive acceptance and holding register
    // ****************************************
    assign rx_done      = m0_rx_fin || (ce_i && a_done);
    assign rx_byte      = m0_rx_fin ? {rxd_sync, m0_shift[7:1]} : a_data;
    assign rx_ninth_new = (mode == usp_pkg::MODE_UART8) ? a_stop : a_ninth;

    always_comb begin
        if (mode == usp_pkg::MODE_SHIFT) begin
            rx_pass = 1'b1;
        end else if (mode == usp_pkg::MODE_UART8) begin
            rx_pass = !mp || a_stop;
        end else begin
            rx_pass = !mp || a_ninth;
        end
    end

    assign rx_accept = rx_done && !ri && rx_pass;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rx_hold <= 8'h00;
        end else if (rx_accept) begin
            rx_hold <= rx_byte;
        end
    end

    // ****************************************
    // serial_control register
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            mode <= usp_pkg::SERIAL_CONTROL_RESET[usp_pkg::SC_MODE_LOW:usp_pkg::SC_MODE_HIGH];
            mp   <= usp_pkg::SERIAL_CONTROL_RESET[usp_pkg::SC_MP];
            ren  <= usp_pkg::SERIAL_CONTROL_RESET[usp_pkg::SC_REN];
            tb8  <= usp_pkg::SERIAL_CONTROL_RESET[usp_pkg::SC_TB8];
        end else if (wr_serial_control) begin
            mode <= {fes ? mode[1] : sfr_wdata_i[usp_pkg::SC_MODE_LOW],
                     sfr_wdata_i[usp_pkg::SC_MODE_HIGH]};
            mp   <= sfr_wdata_i[usp_pkg::SC_MP];
            ren  <= sfr_wdata_i[usp_pkg::SC_REN];
            tb8  <= sfr_wdata_i[usp_pkg::SC_TB8];
        end
    end

    // hardware set wins over software clear
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ti  <= usp_pkg::SERIAL_CONTROL_RESET[usp_pkg::SC_TI];
            ri  <= usp_pkg::SERIAL_CONTROL_RESET[usp_pkg::SC_RI];
            rb8 <= usp_pkg::SERIAL_CONTROL_RESET[usp_pkg::SC_RB8];
            fe  <= 1'b0;
        end else if (ce_i) begin
            ti <= tx_fin || (wr_serial_control ? sfr_wdata_i[usp_pkg::SC_TI] : ti);
            ri <= rx_accept || (wr_serial_control ? sfr_wdata_i[usp_pkg::SC_RI] : ri);
            fe <= (a_done && !a_stop) || ((wr_serial_control && fes) ? sfr_wdata_i[usp_pkg::SC_MODE_LOW] : fe);
            if (rx_accept && (mode != usp_pkg::MODE_SHIFT)) begin
                rb8 <= rx_ninth_new;
            end else if (wr_serial_control) begin
                rb8 <= sfr_wdata_i[usp_pkg::SC_RB8];
            end
        end
    end

    // ****************************************
    // read data and interrupt
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sfr_rdata_o <= usp_pkg::RDATA_NONE;
        end else if (ce_i && sfr_rd_i) begin
            if (sfr_addr_i == usp_pkg::SERIAL_CONTROL_ADDR) begin
                sfr_rdata_o <= {fes ? fe : mode[1], mode[0], mp, ren, tb8, rb8, ti, ri};
            end else if (sfr_addr_i == usp_pkg::SERIAL_BUFFER_ADDR) begin
                sfr_rdata_o <= rx_hold;
            end else begin
                sfr_rdata_o <= usp_pkg::RDATA_NONE;
            end
        end
    end

    assign serial_irq_o = ti || ri;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    property p_tx_start;
        wr_serial_buffer && state == usp_pkg::ln_idle && mode != usp_pkg::MODE_SHIFT
            |=> state == usp_pkg::ln_tx_async;
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("async tx did not start");

    property p_m0_clock;
        ce_i && state == usp_pkg::ln_sync_tx && !ph |=> !txd_o && !rxd_oe_n_o;
    endproperty
    a_m0_clock: assert property (p_m0_clock) else $error("shift clock not low");

    property p_m0_rx_start;
        ce_i && state == usp_pkg::ln_idle && m0_rx_go |=> state == usp_pkg::ln_sync_rx;
    endproperty
    a_m0_rx_start: assert property (p_m0_rx_start) else $error("mode 0 rx not started");

    property p_ri_sticky;
        ri && !wr_serial_control |=> ri;
    endproperty
    a_ri_sticky: assert property (p_ri_sticky) else $error("rx flag dropped");

    property p_lost;
        rx_done && ri |=> rx_hold == $past(rx_hold);
    endproperty
    a_lost: assert property (p_lost) else $error("holding overwritten");

    property p_rb8_stop;
        rx_accept && mode == usp_pkg::MODE_UART8 |=> rb8 == $past(a_stop) && ri;
    endproperty
    a_rb8_stop: assert property (p_rb8_stop) else $error("stop not in rb8");

    property p_rb8_ninth;
        rx_accept && mode[1] |=> rb8 == $past(a_ninth) && rx_hold == $past(a_data);
    endproperty
    a_rb8_ninth: assert property (p_rb8_ninth) else $error("ninth not in rb8");

    property p_mp_filter;
        ce_i && a_done && mp && mode[1] && !a_ninth |=> ri == $past(ri);
    endproperty
    a_mp_filter: assert property (p_mp_filter) else $error("filtered byte raised flag");

    property p_tx_irq;
        tx_fin |=> ti && serial_irq_o;
    endproperty
    a_tx_irq: assert property (p_tx_irq) else $error("tx done not flagged");

    c_tx9: cover property (tx_fin && mode == usp_pkg::MODE_UART9T);
    c_m0_rx: cover property (m0_rx_fin && rx_accept);
    c_lost: cover property (rx_done && ri);
endmodule
`default_nettype wire

/* File: rtl/usp_pkg.sv */
// usp_pkg: constants and types shared by the serial port design files.
// assumes one core clock; the register port uses byte addresses of the special function space.
package usp_pkg;

    // ****************************************
    // register addresses and reset values
    // ****************************************
    localparam logic [7:0] SERIAL_CONTROL_ADDR  = 8'h98;
    localparam logic [7:0] SERIAL_BUFFER_ADDR  = 8'h99;
    localparam logic [7:0] SERIAL_CONTROL_RESET = 8'h00;
    localparam logic [7:0] RDATA_NONE = 8'h00;

    // ****************************************
    // serial_control field positions
    // ****************************************
    localparam int SC_MODE_LOW  = 7;
    localparam int SC_MODE_HIGH = 6;
    localparam int SC_MP        = 5;
    localparam int SC_REN       = 4;
    localparam int SC_TB8       = 3;
    localparam int SC_RB8       = 2;
    localparam int SC_TI        = 1;
    localparam int SC_RI        = 0;

    // ****************************************
    // modes, frame lengths, timing counts
    // ****************************************
    localparam logic [1:0] MODE_SHIFT  = 2'h0;
    localparam logic [1:0] MODE_UART8  = 2'h1;
    localparam logic [1:0] MODE_UART9F = 2'h2;
    localparam logic [1:0] MODE_UART9T = 2'h3;
    localparam logic [3:0] SYNC_BITS   = 4'h8;
    localparam logic [3:0] FRAME_BITS8 = 4'hA;
    localparam logic [3:0] FRAME_BITS9 = 4'hB;
    localparam logic [3:0] DATA_BITS8  = 4'h8;
    localparam logic [3:0] DATA_BITS9  = 4'h9;
    localparam logic [3:0] OS_LAST     = 4'hF;
    localparam logic [3:0] OS_MID      = 4'h7;

    // ****************************************
    // state types
    // ****************************************
    typedef enum logic [3:0] {
        ln_idle     = 4'b0001,
        ln_tx_async = 4'b0010,
        ln_sync_tx  = 4'b0100,
        ln_sync_rx  = 4'b1000
    } usp_line_t;

    typedef enum logic [3:0] {
        rx_idle  = 4'b0001,
        rx_start = 4'b0010,
        rx_data  = 4'b0100,
        rx_stop  = 4'b1000
    } usp_rx_t;

endpackage

/* File: rtl/usp_async_rx.sv */
// usp_async_rx: asynchronous receiver, 16 samples per bit, 8 or 9 data bits.
// assumes rxd_i already synchronised and os_tick_i a one-cycle pulse on clk_i.
`timescale 1ns/100ps
`default_nettype none
module usp_async_rx (
    // clock, reset, enable
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic       ce_i,
    // control
    input  wire logic       os_tick_i,
    input  wire logic       rx_en_i,
    input  wire logic       nine_bit_i,
    input  wire logic       rxd_i,
    // received frame
    output logic            done_o,
    output logic [7:0]      data_o,
    output logic            ninth_o,
    output logic            stop_o
);
    usp_pkg::usp_rx_t state;
    logic [3:0]       os_cnt;
    logic [3:0]       bit_cnt;
    logic [8:0]       shift;
    logic             rxd_prev;

    // ****************************************
    // frame receiver
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state    <= usp_pkg::rx_idle;
            os_cnt   <= 4'h0;
            bit_cnt  <= 4'h0;
            shift    <= 9'h000;
            rxd_prev <= 1'b1;
            done_o   <= 1'b0;
            data_o   <= 8'h00;
            ninth_o  <= 1'b0;
            stop_o   <= 1'b0;
        end else if (ce_i) begin
            done_o   <= 1'b0;
            rxd_prev <= rxd_i;
            case (state)
                usp_pkg::rx_idle: begin
                    os_cnt <= 4'h0;
                    if (rx_en_i && rxd_prev && !rxd_i) begin
                        state <= usp_pkg::rx_start;
                    end
                end
                usp_pkg::rx_start: begin
                    if (os_tick_i) begin
                        os_cnt <= os_cnt + 4'h1;
                        if (os_cnt == usp_pkg::OS_MID) begin
                            os_cnt  <= 4'h0;
                            bit_cnt <= nine_bit_i ? usp_pkg::DATA_BITS9 : usp_pkg::DATA_BITS8;
                            state   <= rxd_i ? usp_pkg::rx_idle : usp_pkg::rx_data;
                        end
                    end
                end
                usp_pkg::rx_data: begin
                    if (os_tick_i) begin
                        os_cnt <= os_cnt + 4'h1;
                        if (os_cnt == usp_pkg::OS_LAST) begin
                            shift   <= {rxd_i, shift[8:1]};
                            bit_cnt <= bit_cnt - 4'h1;
                            if (bit_cnt == 4'h1) begin
                                state <= usp_pkg::rx_stop;
                            end
                        end
                    end
                end
                usp_pkg::rx_stop: begin
                    if (os_tick_i) begin
                        os_cnt <= os_cnt + 4'h1;
                        if (os_cnt == usp_pkg::OS_LAST) begin
                            data_o  <= nine_bit_i ? shift[7:0] : shift[8:1];
                            ninth_o <= shift[8];
                            stop_o  <= rxd_i;
                            done_o  <= 1'b1;
                            state   <= usp_pkg::rx_idle;
                        end
                    end
                end
                default: state <= usp_pkg::rx_idle;
            endcase
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    property p_no_start_off;
        state == usp_pkg::rx_idle && !rx_en_i |=> state == usp_pkg::rx_idle;
    endproperty
    a_no_start_off: assert property (p_no_start_off) else $error("rx started while disabled");

    property p_false_start;
        ce_i && os_tick_i && state == usp_pkg::rx_start && os_cnt == usp_pkg::OS_MID && rxd_i
            |=> state == usp_pkg::rx_idle;
    endproperty
    a_false_start: assert property (p_false_start) else $error("false start not rejected");

    c_frame_done: cover property (done_o && ninth_o);
endmodule
`default_nettype wire

/* File: bench/usp_remote_node.sv */
// usp_remote_node: far serial node that sends and captures async frames.
// assumes 16 clk_i cycles per bit and an idle-high line.
`timescale 1ns/100ps
`default_nettype none
module usp_remote_node (
    // clock and line
    input  wire logic clk_i,
    input  wire logic txd_i,
    output logic      rxd_o
);
    logic [7:0] got_data;
    logic       got_ninth;
    logic       got_stop;
    initial rxd_o = 1'b1;
    task automatic send(input logic [7:0] d, input logic nine, input logic b9);
        logic [10:0] f;
        f = nine ? {1'b1, b9, d, 1'b0} : {2'b11, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            rxd_o <= f[i];
            repeat (16) @(posedge clk_i);
        end
    endtask
    task automatic recv(input logic nine);
        @(negedge txd_i);
        repeat (8) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (16) @(posedge clk_i);
            got_data[i] = txd_i;
        end
        if (nine) begin
            repeat (16) @(posedge clk_i);
            got_ninth = txd_i;
        end
        repeat (16) @(posedge clk_i);
        got_stop = txd_i;
    endtask
endmodule
`default_nettype wire

/* File: bench/usp_serial_port_bench.sv */
// usp_serial_port_bench: register-level tests of the serial port.
// assumes the remote node model and 16 cycles per bit in modes 1 to 3.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
module usp_serial_port_bench;
    logic       clk_i   = 1'b0;
    logic       reset_i = 1'b1;
    logic [7:0] addr    = 8'h00;
    logic [7:0] wdata   = 8'h00;
    logic       wr      = 1'b0;
    logic       rd      = 1'b0;
    logic [7:0] m0      = 8'h5A;
    logic [7:0] ctl;
    logic [7:0] rdata;
    logic       rxd, rxd_o, oe_n, txd, irq;
    int         n_mismatch = 0;
    int         checks     = 0;
    int         cyc        = 0;
    always #12.5 clk_i = ~clk_i;
    usp_serial_port i_dut (.clk_i(clk_i), .reset_i(reset_i), .ce_i(1'b1),
        .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wdata),
        .sfr_rdata_o(rdata), .baud_tick_i(1'b1), .double_rate_i(1'b1),
        .frame_error_access_select_i(1'b0), .rxd_i(rxd), .rxd_o(rxd_o),
        .rxd_oe_n_o(oe_n), .txd_o(txd), .serial_irq_o(irq));
    usp_remote_node i_node (.clk_i(clk_i), .txd_i(txd), .rxd_o(rxd));
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #2 addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge clk_i);
        #2 wr = 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        #2 addr = a;
        rd = 1'b1;
        @(posedge clk_i);
        #2 rd = 1'b0;
        `CHK("sfr read", e, rdata)
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            summarize();
        end
    end
    initial begin
        repeat (16) @(posedge clk_i);
        #2 reset_i = 1'b0;
        rchk(8'h98, 8'h00);
        rchk(8'h9A, 8'h00);
        for (int m = 1; m < 4; m++) begin
            ctl = {m[1:0], 6'b011000};
            wreg(8'h98, ctl);
            fork
                wreg(8'h99, 8'hA5 ^ m[7:0]);
                i_node.send(8'h3C + m[7:0], m > 1, m[0]);
                i_node.recv(m > 1);
            join
            repeat (16) @(posedge clk_i);
            #2 `CHK("tx data", 8'hA5 ^ m[7:0], i_node.got_data)
            if (m > 1) `CHK("tx ninth", 1'b1, i_node.got_ninth)
            `CHK("tx stop", 1'b1, i_node.got_stop)
            `CHK("irq set", 1'b1, irq)
            rchk(8'h98, ctl | {5'h00, (m == 1) | m[0], 2'b11});
            rchk(8'h99, 8'h3C + m[7:0]);
            wreg(8'h98, ctl);
            `CHK("irq clear", 1'b0, irq)
        end
        wreg(8'h98, 8'hF0);
        i_node.send(8'h11, 1'b1, 1'b0);
        rchk(8'h98, 8'hF0);
        i_node.send(8'h22, 1'b1, 1'b1);
        rchk(8'h98, 8'hF5);
        i_node.send(8'h33, 1'b1, 1'b1);
        rchk(8'h99, 8'h22);
        wreg(8'h98, 8'h10);
        repeat (20) @(posedge clk_i);
        rchk(8'h98, 8'h11);
        rchk(8'h99, 8'hFF);
        wreg(8'h98, 8'h00);
        wreg(8'h99, m0);
        @(posedge clk_i);
        #2;
        for (int i = 0; i < 8; i++) begin
            `CHK("shift data", m0[i], rxd_o)
            `CHK("shift oe", 1'b0, oe_n)
            `CHK("shift clock", 1'b0, txd)
            #50;
        end
        `CHK("shift release", 1'b1, oe_n)
        `CHK("shift done", 1'b1, irq)
        summarize();
    end
endmodule
`default_nettype wire
